// >>> common/acsq_pkg.sv
// Shared constants for the two-sequencer converter register block.
package acsq_pkg;
    // Register byte offsets.
    localparam logic [11:0] ACSQ_SEL1_OFS   = 12'h060;
    localparam logic [11:0] ACSQ_CTL1_OFS   = 12'h064;
    localparam logic [11:0] ACSQ_FIFO1_OFS  = 12'h068;
    localparam logic [11:0] ACSQ_STAT1_OFS  = 12'h06c;
    localparam logic [11:0] ACSQ_SEL2_OFS   = 12'h080;
    localparam logic [11:0] ACSQ_CTL2_OFS   = 12'h084;
    localparam logic [11:0] ACSQ_FIFO2_OFS  = 12'h088;
    localparam logic [11:0] ACSQ_STAT2_OFS  = 12'h08c;
    localparam logic [11:0] ACSQ_OVF_OFS    = 12'h0c0;
    localparam logic [11:0] ACSQ_UNF_OFS    = 12'h0c4;
    localparam logic [11:0] ACSQ_ISTAT_OFS  = 12'h0c8;
    localparam logic [11:0] ACSQ_IMASK_OFS  = 12'h0cc;
    localparam int          ACSQ_AW         = 12;
    localparam int          ACSQ_DW         = 32;

    // Configuration register layout.
    localparam int          ACSQ_CFG_W      = 16;
    localparam logic [15:0] ACSQ_SEL_MASK   = 16'h7777;
    localparam logic [15:0] ACSQ_CTL_MASK   = 16'hffff;
    localparam logic [15:0] ACSQ_CFG_RESET  = 16'h0000;
    localparam int          ACSQ_NIB_W      = 4;
    localparam int          ACSQ_NIB_DIFF   = 0;
    localparam int          ACSQ_NIB_LAST   = 1;
    localparam int          ACSQ_NIB_IE     = 2;
    localparam int          ACSQ_NIB_TS     = 3;
    localparam int          ACSQ_SAMPLES    = 4;

    // FIFO status layout.
    localparam int          ACSQ_FST_FULL   = 12;
    localparam int          ACSQ_FST_EMPTY  = 8;
    localparam int          ACSQ_FST_HPTR   = 4;
    localparam int          ACSQ_FST_TPTR   = 0;
    localparam logic [31:0] ACSQ_FST_RESET  = 32'h00000100;

    // Event register layout: bit n belongs to sequencer n.
    localparam int          ACSQ_EV_W       = 4;
    localparam int          ACSQ_SEQ_BASE   = 1;
    localparam int          ACSQ_NSEQ       = 2;

    // Result path.
    localparam int          ACSQ_DATA_W     = 10;
    localparam int          ACSQ_FIFO_DEPTH = 4;
    localparam int          ACSQ_PTR_W      = 4;
endpackage : acsq_pkg

// >>> logic/acsq_fifo.sv
// Result FIFO of one sequencer, flip-flop storage with head and tail indices.
`timescale 1ns/1ps
module acsq_fifo
    import acsq_pkg::*;
#(
    parameter int W     = ACSQ_DATA_W,
    parameter int DEPTH = ACSQ_FIFO_DEPTH,
    parameter int PW    = ACSQ_PTR_W
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_ce,
    input  wire logic          i_push,
    input  wire logic [W-1:0]  i_push_data,
    input  wire logic          i_pop,
    output logic      [W-1:0]  o_head,
    output logic               o_full,
    output logic               o_empty,
    output logic      [PW-1:0] o_hptr,
    output logic      [PW-1:0] o_tptr,
    output logic               o_overflow,
    output logic               o_underflow
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           hptr;
        logic [PW-1:0]           tptr;
        logic [PW:0]             cnt;
    } acsq_fifo_st_t;

    acsq_fifo_st_t           st_ff;
    acsq_fifo_st_t           nxt_st;
    logic [DEPTH-1:0][W-1:0] nxt_mem;
    logic                    do_push;
    logic                    do_pop;

    assign o_full      = (st_ff.cnt == (PW+1)'(DEPTH));
    assign o_empty     = (st_ff.cnt == '0);
    assign o_hptr      = st_ff.hptr;
    assign o_tptr      = st_ff.tptr;
    assign o_head      = st_ff.mem[st_ff.tptr];
    assign do_push     = i_push && !o_full;
    assign do_pop      = i_pop && !o_empty;
    assign o_overflow  = i_push && o_full;
    assign o_underflow = i_pop && o_empty;

    for (genvar e = 0; e < DEPTH; e++) begin : g_entry
        assign nxt_mem[e] = (do_push && st_ff.hptr == PW'(e)) ?
                            i_push_data : st_ff.mem[e];
    end

    always_comb begin
        nxt_st     = st_ff;
        nxt_st.mem = nxt_mem;
        if (do_push) begin
            nxt_st.hptr = (st_ff.hptr == PW'(DEPTH - 1)) ?
                          '0 : st_ff.hptr + PW'(1);
        end
        if (do_pop) begin
            nxt_st.tptr = (st_ff.tptr == PW'(DEPTH - 1)) ?
                          '0 : st_ff.tptr + PW'(1);
        end
        nxt_st.cnt = st_ff.cnt + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end

    // empty with both indices at zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    fifo_reset_a: assert property ($rose(i_rst_n) |->
        o_empty && !o_full && o_hptr == '0 && o_tptr == '0)
        else $error("fifo not empty after reset");

    sequence push_into_empty_s;
        i_ce && i_push && !i_pop && o_empty;
    endsequence

    fifo_order_a: assert property (push_into_empty_s |=>
        !o_empty && o_head == $past(i_push_data))
        else $error("first result not at fifo head");
endmodule : acsq_fifo

// >>> logic/acsq_top.sv
// Register block for two four-sample converter sequencers and their FIFOs.
`timescale 1ns/1ps
module acsq_top
    import acsq_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_ce,
    input  wire logic [ACSQ_AW-1:0]     i_addr,
    input  wire logic [ACSQ_DW-1:0]     i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [ACSQ_DW-1:0]     o_rdata,
    input  wire logic                   i_seq1_res_valid,
    input  wire logic [ACSQ_DATA_W-1:0] i_seq1_res_data,
    input  wire logic [1:0]             i_seq1_res_sample,
    input  wire logic                   i_seq2_res_valid,
    input  wire logic [ACSQ_DATA_W-1:0] i_seq2_res_data,
    input  wire logic [1:0]             i_seq2_res_sample,
    output logic      [ACSQ_CFG_W-1:0]  o_seq1_input_select,
    output logic      [ACSQ_CFG_W-1:0]  o_seq1_sample_control,
    output logic      [ACSQ_CFG_W-1:0]  o_seq2_input_select,
    output logic      [ACSQ_CFG_W-1:0]  o_seq2_sample_control,
    output logic                        o_irq
);
    typedef struct packed {
        logic [ACSQ_NSEQ-1:0][ACSQ_CFG_W-1:0] sel;
        logic [ACSQ_NSEQ-1:0][ACSQ_CFG_W-1:0] ctl;
        logic [ACSQ_EV_W-1:0]                 ovf;
        logic [ACSQ_EV_W-1:0]                 unf;
        logic [ACSQ_EV_W-1:0]                 istat;
        logic [ACSQ_EV_W-1:0]                 imask;
        logic [ACSQ_DW-1:0]                   rdata;
        logic                                 irq;
    } acsq_top_st_t;

    localparam logic [ACSQ_AW-1:0] SEL_OFS [ACSQ_NSEQ] =
        '{ACSQ_SEL1_OFS, ACSQ_SEL2_OFS};
    localparam logic [ACSQ_AW-1:0] CTL_OFS [ACSQ_NSEQ] =
        '{ACSQ_CTL1_OFS, ACSQ_CTL2_OFS};
    localparam logic [ACSQ_AW-1:0] FIFO_OFS [ACSQ_NSEQ] =
        '{ACSQ_FIFO1_OFS, ACSQ_FIFO2_OFS};
    localparam logic [ACSQ_AW-1:0] STAT_OFS [ACSQ_NSEQ] =
        '{ACSQ_STAT1_OFS, ACSQ_STAT2_OFS};

    // Reset is released through two flops so every register and FIFO flop leaves reset
    // on the same edge.
    logic [1:0]                           rst_sync_ff;
    logic                                 rst_n;
    acsq_top_st_t                         st_ff;
    acsq_top_st_t                         nxt_st;

    logic [ACSQ_NSEQ-1:0]                 res_valid;
    logic [ACSQ_NSEQ-1:0][ACSQ_DATA_W-1:0] res_data;
    logic [ACSQ_NSEQ-1:0][1:0]            res_sample;
    logic [ACSQ_NSEQ-1:0]                 pop;
    logic [ACSQ_NSEQ-1:0][ACSQ_DATA_W-1:0] f_head;
    logic [ACSQ_NSEQ-1:0]                 f_full;
    logic [ACSQ_NSEQ-1:0]                 f_empty;
    logic [ACSQ_NSEQ-1:0][ACSQ_PTR_W-1:0] f_hptr;
    logic [ACSQ_NSEQ-1:0][ACSQ_PTR_W-1:0] f_tptr;
    logic [ACSQ_NSEQ-1:0]                 f_ovf;
    logic [ACSQ_NSEQ-1:0]                 f_unf;
    logic [ACSQ_NSEQ-1:0]                 smp_irq;
    logic [ACSQ_NSEQ-1:0][ACSQ_DW-1:0]    fstat;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    assign res_valid  = {i_seq2_res_valid, i_seq1_res_valid};
    assign res_data   = {i_seq2_res_data, i_seq1_res_data};
    assign res_sample = {i_seq2_res_sample, i_seq1_res_sample};

    for (genvar s = 0; s < ACSQ_NSEQ; s++) begin : g_seq
        // a read of the result word pops
        assign pop[s] = i_ce && i_rd && (i_addr == FIFO_OFS[s]);

        // The sample tag only picks the interrupt enable nibble; order
        // inside the FIFO is arrival order from the converter.
        assign smp_irq[s] = res_valid[s] &&
            st_ff.ctl[s][ACSQ_NIB_W*res_sample[s] + ACSQ_NIB_IE];

        logic [ACSQ_DW-1:0] stat_word;

        // status word packs flags and pointers
        always_comb begin
            stat_word                 = '0;
            stat_word[ACSQ_FST_FULL]  = f_full[s];
            stat_word[ACSQ_FST_EMPTY] = f_empty[s];
            stat_word[ACSQ_FST_HPTR +: ACSQ_PTR_W] = f_hptr[s];
            stat_word[ACSQ_FST_TPTR +: ACSQ_PTR_W] = f_tptr[s];
        end
        assign fstat[s] = stat_word;

        acsq_fifo #(
            .W     (ACSQ_DATA_W),
            .DEPTH (ACSQ_FIFO_DEPTH),
            .PW    (ACSQ_PTR_W)
        ) u_fifo (
            .i_clk       (i_clk),
            .i_rst_n     (rst_n),
            .i_ce        (i_ce),
            .i_push      (res_valid[s]),
            .i_push_data (res_data[s]),
            .i_pop       (pop[s]),
            .o_head      (f_head[s]),
            .o_full      (f_full[s]),
            .o_empty     (f_empty[s]),
            .o_hptr      (f_hptr[s]),
            .o_tptr      (f_tptr[s]),
            .o_overflow  (f_ovf[s]),
            .o_underflow (f_unf[s])
        );
    end

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.rdata = '0;

        for (int s = 0; s < ACSQ_NSEQ; s++) begin
            if (i_wr) begin
                if (i_addr == SEL_OFS[s]) begin
                    nxt_st.sel[s] = i_wdata[ACSQ_CFG_W-1:0] & ACSQ_SEL_MASK;
                end
                if (i_addr == CTL_OFS[s]) begin
                    nxt_st.ctl[s] = i_wdata[ACSQ_CFG_W-1:0] & ACSQ_CTL_MASK;
                end
            end
            if (i_rd) begin
                // upper sixteen bits read as zero
                if (i_addr == SEL_OFS[s]) begin
                    nxt_st.rdata = {16'h0000, st_ff.sel[s]};
                end
                if (i_addr == CTL_OFS[s]) begin
                    nxt_st.rdata = {16'h0000, st_ff.ctl[s]};
                end
                // oldest result returned, zero when empty
                if (i_addr == FIFO_OFS[s] && !f_empty[s]) begin
                    nxt_st.rdata = {{(ACSQ_DW-ACSQ_DATA_W){1'b0}},
                                    f_head[s]};
                end
                if (i_addr == STAT_OFS[s]) begin
                    nxt_st.rdata = fstat[s];
                end
            end
        end

        if (i_rd) begin
            case (i_addr)
                ACSQ_OVF_OFS:   nxt_st.rdata = {28'h0, st_ff.ovf};
                ACSQ_UNF_OFS:   nxt_st.rdata = {28'h0, st_ff.unf};
                ACSQ_ISTAT_OFS: nxt_st.rdata = {28'h0, st_ff.istat};
                ACSQ_IMASK_OFS: nxt_st.rdata = {28'h0, st_ff.imask};
                default:        ;
            endcase
        end

        // Write-one-to-clear first; a new event in the same cycle is set
        // afterwards so it is never lost.
        if (i_wr) begin
            case (i_addr)
                ACSQ_OVF_OFS:
                    nxt_st.ovf = st_ff.ovf & ~i_wdata[ACSQ_EV_W-1:0];
                ACSQ_UNF_OFS:
                    nxt_st.unf = st_ff.unf & ~i_wdata[ACSQ_EV_W-1:0];
                ACSQ_ISTAT_OFS:
                    nxt_st.istat = st_ff.istat & ~i_wdata[ACSQ_EV_W-1:0];
                ACSQ_IMASK_OFS:
                    nxt_st.imask = i_wdata[ACSQ_EV_W-1:0];
                default: ;
            endcase
        end

        for (int s = 0; s < ACSQ_NSEQ; s++) begin
            if (f_ovf[s]) begin
                nxt_st.ovf[ACSQ_SEQ_BASE + s] = 1'b1;
            end
            if (f_unf[s]) begin
                nxt_st.unf[ACSQ_SEQ_BASE + s] = 1'b1;
            end
            if (smp_irq[s]) begin
                nxt_st.istat[ACSQ_SEQ_BASE + s] = 1'b1;
            end
        end

        nxt_st.irq = |(nxt_st.istat & nxt_st.imask);
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata               = st_ff.rdata;
    assign o_seq1_input_select   = st_ff.sel[0];
    assign o_seq1_sample_control = st_ff.ctl[0];
    assign o_seq2_input_select   = st_ff.sel[1];
    assign o_seq2_sample_control = st_ff.ctl[1];
    assign o_irq                 = st_ff.irq;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    sequence wr_sel1_s;
        i_ce && i_wr && i_addr == ACSQ_SEL1_OFS;
    endsequence

    sequence wr_ctl2_s;
        i_ce && i_wr && i_addr == ACSQ_CTL2_OFS;
    endsequence

    sequence rd_fifo1_s;
        i_ce && i_rd && i_addr == ACSQ_FIFO1_OFS;
    endsequence

    sequence rd_stat2_s;
        i_ce && i_rd && i_addr == ACSQ_STAT2_OFS;
    endsequence

    sel_write_a: assert property (wr_sel1_s |=>
        o_seq1_input_select == ($past(i_wdata[15:0]) & ACSQ_SEL_MASK))
        else $error("input select not stored with gaps cleared");

    ctl_write_a: assert property (wr_ctl2_s |=>
        o_seq2_sample_control == $past(i_wdata[15:0]))
        else $error("sample control not stored");

    fifo_read_a: assert property (rd_fifo1_s ##0 !f_empty[0] |=>
        o_rdata == {22'h0, $past(f_head[0])} &&
        f_tptr[0] != $past(f_tptr[0]))
        else $error("result read did not return and pop head");

    ovf_flag_a: assert property (
        i_ce && i_seq2_res_valid && f_full[1] && !pop[1] |=>
        st_ff.ovf[2] && f_full[1])
        else $error("overflow not recorded");

    unf_flag_a: assert property (rd_fifo1_s ##0 f_empty[0] |=>
        st_ff.unf[1] && o_rdata == 32'h0)
        else $error("underflow not recorded");

    fstat_read_a: assert property (rd_stat2_s |=>
        o_rdata[ACSQ_FST_EMPTY] == $past(f_empty[1]) &&
        o_rdata[ACSQ_FST_FULL] == $past(f_full[1]) &&
        o_rdata[7:0] == {$past(f_hptr[1]), $past(f_tptr[1])})
        else $error("fifo status word wrong");

    fstat_reset_a: assert property ($rose(rst_n) |->
        fstat[0] == ACSQ_FST_RESET && fstat[1] == ACSQ_FST_RESET)
        else $error("fifo status not at reset value");

    upper_zero_a: assert property (
        i_ce && i_rd && (i_addr == ACSQ_SEL2_OFS ||
        i_addr == ACSQ_CTL1_OFS) |=> o_rdata[31:16] == 16'h0000)
        else $error("upper half of config read not zero");

    irq_level_a: assert property (
        i_ce && smp_irq[1] && st_ff.imask[2] &&
        !(i_wr && i_addr == ACSQ_IMASK_OFS) |=> o_irq && st_ff.istat[2])
        else $error("unmasked sample event did not raise irq");
endmodule : acsq_top

// >>> verif/acsq_conv_model.sv
// Behavioural converter core answering one sequencer with results.
`timescale 1ns/1ps
module acsq_conv_model
    import acsq_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_start,
    input  wire logic [3:0]             i_gap,
    input  wire logic [ACSQ_CFG_W-1:0]  i_input_select,
    input  wire logic [ACSQ_CFG_W-1:0]  i_sample_control,
    output logic                        o_res_valid,
    output logic      [ACSQ_DATA_W-1:0] o_res_data,
    output logic      [1:0]             o_res_sample
);
    initial begin
        o_res_valid  = 1'b0;
        o_res_data   = 10'h155;
        o_res_sample = 2'h0;
    end

    always begin : run_seq
        int   k;
        logic last;
        @(posedge i_clk);
        if (i_start) begin
            for (k = 0; k < ACSQ_SAMPLES; k++) begin
                last = i_sample_control[4*k+ACSQ_NIB_LAST] || (k == 3);
                o_res_valid  <= 1'b1;
                o_res_sample <= k[1:0];
                o_res_data   <= {i_input_select[4*k+:3], k[1:0], 5'h0a};
                @(posedge i_clk);
                // Idle data is inverted so a stale value never looks valid.
                if (last || i_gap != 4'h0) begin
                    o_res_valid <= 1'b0;
                    o_res_data  <= ~o_res_data;
                end
                if (last) begin
                    break;
                end
                repeat (i_gap) @(posedge i_clk);
            end
        end
    end
endmodule : acsq_conv_model

// >>> verif/tb.sv
// Self-checking testbench for the two-sequencer converter register block.
`timescale 1ns/1ps
module tb;
    import acsq_pkg::*;
    logic                   i_clk;
    logic                   i_reset_n;
    logic                   i_ce;
    logic [ACSQ_AW-1:0]     i_addr;
    logic [ACSQ_DW-1:0]     i_wdata;
    logic                   i_wr;
    logic                   i_rd;
    logic [ACSQ_DW-1:0]     o_rdata;
    logic                   v1;
    logic                   v2;
    logic [ACSQ_DATA_W-1:0] d1;
    logic [ACSQ_DATA_W-1:0] d2;
    logic [1:0]             s1;
    logic [1:0]             s2;
    logic [ACSQ_CFG_W-1:0]  sel1;
    logic [ACSQ_CFG_W-1:0]  ctl1;
    logic [ACSQ_CFG_W-1:0]  sel2;
    logic [ACSQ_CFG_W-1:0]  ctl2;
    logic                   o_irq;
    logic                   start1;
    logic                   start2;
    int                     n_fail = 0;
    int                     total_checks = 0;

    acsq_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_seq1_res_valid(v1), .i_seq1_res_data(d1),
        .i_seq1_res_sample(s1), .i_seq2_res_valid(v2),
        .i_seq2_res_data(d2), .i_seq2_res_sample(s2),
        .o_seq1_input_select(sel1), .o_seq1_sample_control(ctl1),
        .o_seq2_input_select(sel2), .o_seq2_sample_control(ctl2),
        .o_irq(o_irq));
    acsq_conv_model conv1 (.i_clk(i_clk), .i_start(start1), .i_gap(4'h0),
        .i_input_select(sel1), .i_sample_control(ctl1),
        .o_res_valid(v1), .o_res_data(d1), .o_res_sample(s1));
    acsq_conv_model conv2 (.i_clk(i_clk), .i_start(start2), .i_gap(4'h3),
        .i_input_select(sel2), .i_sample_control(ctl2),
        .o_res_valid(v2), .o_res_data(d2), .o_res_sample(s2));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        // Let the registered outputs settle before any caller looks at them.
        #1;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 q = o_rdata;
    endtask : rd

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        rd(a, q);
        check(q, e);
    endtask : rd_chk

    // Polls a side-effect-free register; the bound turns a hang into a fail.
    task automatic wait_reg(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        int          n;
        n = 0;
        do begin
            rd(a, q);
            n++;
        end while (q !== e && n < 40);
        check(q, e);
        if (q !== e) begin
            tally_and_finish();
        end
    endtask : wait_reg

    task automatic start_seq(input int n);
        start1 <= (n == 1);
        start2 <= (n == 2);
        @(posedge i_clk);
        start1 <= 1'b0;
        start2 <= 1'b0;
    endtask : start_seq

    function automatic logic [31:0] res(input logic [15:0] sel, input int k);
        logic [1:0] smp;
        smp = k[1:0];
        return {22'h0, sel[4*k+:3], smp, 5'h0a};
    endfunction : res

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin : main
        int k;
        i_reset_n = 1'b0;
        i_ce      = 1'b1;
        i_addr    = 12'h000;
        i_wdata   = 32'h0;
        i_wr      = 1'b0;
        i_rd      = 1'b0;
        start1    = 1'b0;
        start2    = 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd_chk(ACSQ_SEL1_OFS, 32'h0);
        rd_chk(ACSQ_CTL1_OFS, 32'h0);
        rd_chk(ACSQ_SEL2_OFS, 32'h0);
        rd_chk(ACSQ_CTL2_OFS, 32'h0);
        rd_chk(ACSQ_STAT1_OFS, 32'h00000100);
        rd_chk(ACSQ_STAT2_OFS, 32'h00000100);
        $display("test reset_values done");
        wr(ACSQ_SEL1_OFS, 32'hffffffff);
        rd_chk(ACSQ_SEL1_OFS, 32'h00007777);
        wr(ACSQ_CTL1_OFS, 32'hffffffff);
        rd_chk(ACSQ_CTL1_OFS, 32'h0000ffff);
        check({16'h0, sel1}, 32'h7777);
        wr(ACSQ_STAT1_OFS, 32'hffffffff);
        rd_chk(ACSQ_STAT1_OFS, 32'h00000100);
        rd_chk(12'h070, 32'h0);
        i_ce <= 1'b0;
        wr(ACSQ_SEL2_OFS, 32'h7777);
        i_ce <= 1'b1;
        rd_chk(ACSQ_SEL2_OFS, 32'h0);
        $display("test access_masks done");
        wr(ACSQ_SEL1_OFS, 32'h3521);
        wr(ACSQ_CTL1_OFS, 32'h0240);
        start_seq(1);
        wait_reg(ACSQ_STAT1_OFS, 32'h030);
        rd_chk(ACSQ_ISTAT_OFS, 32'h2);
        check({31'h0, o_irq}, 32'h0);
        wr(ACSQ_IMASK_OFS, 32'h2);
        rd_chk(ACSQ_IMASK_OFS, 32'h2);
        check({31'h0, o_irq}, 32'h1);
        for (k = 0; k < 3; k++) begin
            rd_chk(ACSQ_FIFO1_OFS, res(16'h3521, k));
        end
        rd_chk(ACSQ_STAT1_OFS, 32'h133);
        rd_chk(ACSQ_FIFO1_OFS, 32'h0);
        rd_chk(ACSQ_UNF_OFS, 32'h2);
        wr(ACSQ_UNF_OFS, 32'h2);
        wr(ACSQ_ISTAT_OFS, 32'h2);
        rd_chk(ACSQ_UNF_OFS, 32'h0);
        check({31'h0, o_irq}, 32'h0);
        $display("test seq1_stream done");
        wr(ACSQ_SEL2_OFS, 32'h0246);
        wr(ACSQ_CTL2_OFS, 32'h6000);
        check({16'h0, ctl2}, 32'h6000);
        wr(ACSQ_IMASK_OFS, 32'h6);
        start_seq(2);
        wait_reg(ACSQ_STAT2_OFS, 32'h1000);
        rd_chk(ACSQ_ISTAT_OFS, 32'h4);
        check({31'h0, o_irq}, 32'h1);
        // A one-result run keeps later reads free of second-run data.
        wr(ACSQ_CTL2_OFS, 32'h0002);
        start_seq(2);
        wait_reg(ACSQ_OVF_OFS, 32'h4);
        for (k = 0; k < 4; k++) begin
            rd_chk(ACSQ_FIFO2_OFS, res(16'h0246, k));
        end
        rd_chk(ACSQ_STAT2_OFS, 32'h100);
        $display("test seq2_overflow done");
        tally_and_finish();
    end
endmodule : tb
